// ### core/cacl_pkg.sv
// Package with register map, field positions and constants of the block.
package cacl_pkg;

	// Register byte offsets on the bus.
	localparam logic [7:0] CACL_OFS_CTRL   = 8'h00;
	localparam logic [7:0] CACL_OFS_STATUS = 8'h04;

	// Control register field positions.
	localparam int CACL_CTRL_REFSEL    = 0;
	localparam int CACL_CTRL_OSCSRC    = 1;
	localparam int CACL_CTRL_CLKEN     = 2;
	localparam int CACL_CTRL_DIV_LO    = 4;
	localparam int CACL_CTRL_DIV_HI    = 7;
	localparam int CACL_CTRL_ROUTE_B   = 8;
	localparam int CACL_CTRL_PD_A      = 9;
	localparam int CACL_CTRL_PD_B      = 10;
	localparam int CACL_CTRL_DP_RESET  = 12;

	// Status register field positions.
	localparam int CACL_STAT_REF_SECOND = 0;
	localparam int CACL_STAT_PARTNER_OK = 1;
	localparam int CACL_STAT_TX_OK      = 2;
	localparam int CACL_STAT_PIN_PD_A   = 3;
	localparam int CACL_STAT_PIN_PD_B   = 4;
	localparam int CACL_STAT_A_DOWN     = 5;
	localparam int CACL_STAT_CLK_OFF    = 6;
	localparam int CACL_STAT_NEED_DPRST = 7;

	// Reset value of the control register: first reference, output on.
	localparam logic [12:0] CACL_CTRL_RESET = 13'h0004;

	// Width of the divider ratio carried between modules.
	localparam int CACL_RATIO_W = 5;

	// Divide ratio table, indexed by the control register divide field.
	localparam int CACL_NUM_RATIOS = 9;
	localparam logic [CACL_RATIO_W-1:0] CACL_RATIOS [CACL_NUM_RATIOS] = '{
		5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0a, 5'h10, 5'h14, 5'h19
	};

	// Ratio used for an index outside the table.
	localparam logic [CACL_RATIO_W-1:0] CACL_RATIO_DEFAULT = 5'h01;

	// AHB transfer type bits and response.
	localparam logic [1:0] CACL_HTRANS_NONSEQ = 2'h2;
	localparam logic       CACL_HRESP_OKAY    = 1'h0;

endpackage : cacl_pkg

// ### core/cacl_div_if.sv
// Interface joining the output clock source logic to its divider.
`timescale 1ns/100ps
interface cacl_div_if;
	import cacl_pkg::*;

	logic                    change;
	logic [CACL_RATIO_W-1:0] ratio;
	logic                    out;

	modport src (output change, output ratio, input out);
	modport div (input change, input ratio, output out);

endinterface : cacl_div_if

// ### core/cacl_edge.sv
// Edge detector on a sampled clock-like level.
`timescale 1ns/100ps
module cacl_edge (
	// Clock and reset.
	input  wire logic hclk,
	input  wire logic hresetn,
	// Sampled level and its edges.
	input  wire logic level,
	output logic      rise,
	output logic      change
);

	logic prev;
	logic cur;

	// The level is registered once so that both edges are compared cleanly.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur  <= 1'b0;
			prev <= 1'b0;
		end else begin
			cur  <= level;
			prev <= cur;
		end
	end

	// Edges are combinational pulses of one cycle.
	assign rise   = cur & ~prev;
	assign change = cur ^ prev;

endmodule : cacl_edge

// ### core/cacl_divider.sv
// Half-period counting divider; odd ratios keep a 50 percent duty cycle.
`timescale 1ns/100ps
module cacl_divider (
	// Clock and reset.
	input  wire logic hclk,
	input  wire logic hresetn,
	// Source edges, ratio and divided level.
	cacl_div_if.div   dv
);
	import cacl_pkg::*;

	logic [CACL_RATIO_W-1:0] count;
	logic                    level;

	// The output toggles after ratio source half periods, so its period is
	// exactly ratio source periods for odd and even ratios alike.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= '0;
			level <= 1'b0;
		end else if (dv.change) begin
			if (count + 5'h01 >= dv.ratio) begin
				count <= '0;
				level <= ~level;
			end else begin
				count <= count + 5'h01;
			end
		end
	end

	assign dv.out = level;

endmodule : cacl_divider

// ### core/cacl_top.sv
// Channel A clock selection, output clock and lane status with AHB access.
// How it works
// - Channel A reference is the first reference clock when select is low.
// - After reset the first reference clock is used by default.
// - The output clock is on by default and carries the byte clock.
// - A control bit swaps the source to the oscillator divided by two.
// - Software picks a divide ratio of 1, 2, 4, 5, 8, 10, 16, 20 or 25.
// - During reset the output clock pair is driven to differential zero.
// - The output pair floats when both power-down pins are held low.
// - The output pair floats when both register power-down bits are set.
// - Software can route the channel A byte clock to the B output pair.
// - The partner drives its receive alignment state on the input pin.
// - The transmit alignment output shows channel A lane alignment while channel A is not powered down.
// - Channel A stays powered down while its power-down pin is low.
`timescale 1ns/100ps
module cacl_top (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Reference clocks and selection.
	input  wire logic        ref_clock_first,
	input  wire logic        ref_clock_second,
	input  wire logic        chan_a_refsel_in,
	output logic             chan_a_ref_clock,
	// Clock sources for the output clocks.
	input  wire logic        chan_a_byte_clock,
	input  wire logic        osc_clock,
	input  wire logic        chan_b_native_clock,
	// Channel A output clock pair.
	output logic             chan_a_clock_out_p,
	output logic             chan_a_clock_out_n,
	output logic             chan_a_clock_out_oe,
	// Channel B output clock pair.
	output logic             chan_b_clock_out_p,
	output logic             chan_b_clock_out_n,
	output logic             chan_b_clock_out_oe,
	// Lane alignment status.
	input  wire logic        chan_a_partner_aligned_in,
	input  wire logic        chan_a_tx_lanes_aligned,
	output logic             chan_a_tx_aligned_out,
	// Power-down and data path reset.
	input  wire logic        chan_a_powerdown_n,
	input  wire logic        chan_b_powerdown_n,
	output logic             chan_a_powered_down,
	output logic             chan_a_datapath_reset
);
	import cacl_pkg::*;

	// Bus state.
	logic        dphase_wr;
	logic        dphase_ctrl;
	logic        addr_take;
	logic [12:0] ctrl;
	logic        dp_reset_req;

	// Status state.
	logic        need_dp_reset;
	logic        a_down;
	logic        a_down_prev;
	logic        clk_off;
	logic        partner_ok;

	// Clock path state.
	logic        osc_half;
	logic        byte_level;
	logic        byte_change;
	logic        osc_rise;
	logic        half_change;
	logic [3:0]  div_index;
	logic [CACL_RATIO_W-1:0] next_ratio;
	logic [31:0] next_rdata;
	logic [31:0] status_word;

	cacl_div_if div_bus ();

	// Address phase is taken only for a selected, ready, non-idle transfer.
	assign addr_take = hsel & hready & htrans[1];

	// AHB slave: zero wait states, so hreadyout is held high out of reset
	// and every answer is OKAY, including unmapped addresses.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= CACL_HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= CACL_HRESP_OKAY;
		end
	end

	// Latch the address phase; a write completes in the next data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dphase_wr   <= 1'b0;
			dphase_ctrl <= 1'b0;
		end else if (hready) begin
			dphase_wr   <= addr_take & hwrite;
			dphase_ctrl <= haddr[7:0] == CACL_OFS_CTRL && haddr[31:8] == '0;
		end
	end

	// Status word gathered from the block's own state.
	always_comb begin
		status_word = '0;
		status_word[CACL_STAT_REF_SECOND] = chan_a_ref_clock_sel();
		status_word[CACL_STAT_PARTNER_OK] = partner_ok;
		status_word[CACL_STAT_TX_OK]      = chan_a_tx_aligned_out;
		status_word[CACL_STAT_PIN_PD_A]   = ~chan_a_powerdown_n;
		status_word[CACL_STAT_PIN_PD_B]   = ~chan_b_powerdown_n;
		status_word[CACL_STAT_A_DOWN]     = a_down;
		status_word[CACL_STAT_CLK_OFF]    = clk_off;
		status_word[CACL_STAT_NEED_DPRST] = need_dp_reset;
	end

	// Read data is prepared at the address phase so that it leaves a flop
	// in the data phase; unmapped addresses read as zero.
	always_comb begin
		next_rdata = '0;
		if (haddr[31:8] == '0) begin
			case (haddr[7:0])
				CACL_OFS_CTRL: begin
					next_rdata = {19'h00000, ctrl};
				end
				CACL_OFS_STATUS: begin
					next_rdata = status_word;
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (addr_take && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// Control register; the data path reset bit never stays set.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= CACL_CTRL_RESET;
		end else if (dphase_wr && dphase_ctrl) begin
			ctrl <= hwdata[12:0];
			ctrl[CACL_CTRL_DP_RESET] <= 1'b0;
		end
	end

	// A write of one to the data path reset bit gives a one-cycle request.
	assign dp_reset_req = dphase_wr & dphase_ctrl & hwdata[CACL_CTRL_DP_RESET];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_a_datapath_reset <= 1'b0;
		end else begin
			chan_a_datapath_reset <= dp_reset_req;
		end
	end

	// Reference choice: the pin and the software bit are ORed, which is why
	// the pin must sit low when software is meant to choose.
	function automatic logic chan_a_ref_clock_sel();
		return chan_a_refsel_in | ctrl[CACL_CTRL_REFSEL];
	endfunction : chan_a_ref_clock_sel

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_a_ref_clock <= 1'b0;
		end else if (chan_a_ref_clock_sel()) begin
			chan_a_ref_clock <= ref_clock_second;
		end else begin
			chan_a_ref_clock <= ref_clock_first;
		end
	end

	// Power-down state of channel A from its pin or its register bit.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_down      <= 1'b0;
			a_down_prev <= 1'b0;
		end else begin
			a_down      <= ~chan_a_powerdown_n | ctrl[CACL_CTRL_PD_A];
			a_down_prev <= a_down;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_a_powered_down <= 1'b0;
		end else begin
			chan_a_powered_down <= ~chan_a_powerdown_n
				| ctrl[CACL_CTRL_PD_A];
		end
	end

	// After release the data path is stale until software resets it; the
	// release wins over a reset request landing in the same cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			need_dp_reset <= 1'b0;
		end else if (a_down_prev && !a_down) begin
			need_dp_reset <= 1'b1;
		end else if (dp_reset_req) begin
			need_dp_reset <= 1'b0;
		end
	end

	// Both pins low, or both register bits set, float the output pairs.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_off <= 1'b0;
		end else begin
			clk_off <= (~chan_a_powerdown_n & ~chan_b_powerdown_n)
				| (ctrl[CACL_CTRL_PD_A] & ctrl[CACL_CTRL_PD_B]);
		end
	end

	// Lane alignment status in both directions.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			partner_ok            <= 1'b0;
			chan_a_tx_aligned_out <= 1'b0;
		end else begin
			partner_ok            <= chan_a_partner_aligned_in;
			chan_a_tx_aligned_out <= chan_a_tx_lanes_aligned
				& ~a_down;
		end
	end

	// Edge detectors on the byte clock and the oscillator.
	cacl_edge u_byte_edge (
		.hclk   (hclk),
		.hresetn(hresetn),
		.level  (chan_a_byte_clock),
		.rise   (),
		.change (byte_change)
	);

	cacl_edge u_osc_edge (
		.hclk   (hclk),
		.hresetn(hresetn),
		.level  (osc_clock),
		.rise   (osc_rise),
		.change ()
	);

	// The oscillator is halved first; the divider then counts the edges of
	// the halved clock, one for each of its half periods.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_half <= 1'b0;
		end else if (osc_rise) begin
			osc_half <= ~osc_half;
		end
	end

	// Edges of the halved clock itself feed the divider, so the divided
	// output stays locked to the real osc/2 waveform at a small latency.
	cacl_edge u_half_edge (
		.hclk   (hclk),
		.hresetn(hresetn),
		.level  (osc_half),
		.rise   (),
		.change (half_change)
	);

	// Sampled byte clock level, used for routing to channel B.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			byte_level <= 1'b0;
		end else begin
			byte_level <= chan_a_byte_clock;
		end
	end

	// Ratio lookup; an index outside the table falls back to one.
	assign div_index = ctrl[CACL_CTRL_DIV_HI:CACL_CTRL_DIV_LO];

	always_comb begin
		next_ratio = CACL_RATIO_DEFAULT;
		if (div_index < 4'(CACL_NUM_RATIOS)) begin
			next_ratio = CACL_RATIOS[div_index];
		end
	end

	// Source select feeding the divider.
	assign div_bus.change = ctrl[CACL_CTRL_OSCSRC] ? half_change
		: byte_change;
	assign div_bus.ratio  = next_ratio;

	cacl_divider u_divider (
		.hclk   (hclk),
		.hresetn(hresetn),
		.dv     (div_bus)
	);

	// Channel A pair: differential zero in reset, floating when both pins are low
	// or both power-down bits are set, a steady low pair when software turns the clock off.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_a_clock_out_p  <= 1'b0;
			chan_a_clock_out_n  <= 1'b0;
			chan_a_clock_out_oe <= 1'b1;
		end else begin
			chan_a_clock_out_oe <= ~clk_off;
			if (ctrl[CACL_CTRL_CLKEN]) begin
				chan_a_clock_out_p <= div_bus.out;
				chan_a_clock_out_n <= ~div_bus.out;
			end else begin
				chan_a_clock_out_p <= 1'b0;
				chan_a_clock_out_n <= 1'b0;
			end
		end
	end

	// Channel B pair carries its own clock unless channel A's is routed.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_b_clock_out_p  <= 1'b0;
			chan_b_clock_out_n  <= 1'b0;
			chan_b_clock_out_oe <= 1'b1;
		end else begin
			chan_b_clock_out_oe <= ~clk_off;
			if (ctrl[CACL_CTRL_ROUTE_B]) begin
				chan_b_clock_out_p <= byte_level;
				chan_b_clock_out_n <= ~byte_level;
			end else begin
				chan_b_clock_out_p <= chan_b_native_clock;
				chan_b_clock_out_n <= ~chan_b_native_clock;
			end
		end
	end

endmodule : cacl_top

// ### verification/cacl_monitor.sv
// Concurrent checks on the ports of the channel A clock and status block.
`timescale 1ns/100ps
module cacl_monitor (
	// Clock and reset.
	input wire logic       hclk,
	input wire logic       hresetn,
	// Bus.
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hreadyout,
	input wire logic       hresp,
	// Clock paths.
	input wire logic       ref_clock_second,
	input wire logic       chan_a_refsel_in,
	input wire logic       chan_a_ref_clock,
	input wire logic       chan_a_byte_clock,
	input wire logic       osc_clock,
	input wire logic       chan_a_clock_out_p,
	input wire logic       chan_a_clock_out_n,
	input wire logic       chan_a_clock_out_oe,
	// Status and power-down.
	input wire logic       chan_a_tx_lanes_aligned,
	input wire logic       chan_a_tx_aligned_out,
	input wire logic       chan_a_powerdown_n,
	input wire logic       chan_b_powerdown_n,
	input wire logic       chan_a_powered_down,
	input wire logic       chan_a_datapath_reset
);
	import cacl_pkg::*;

	logic       last_byte;
	logic       last_osc;
	logic [3:0] quiet;

	// Counts cycles with no source edge and no bus request, since only
	// those can move the output clock; the count saturates at 15.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_byte <= 1'b0;
			last_osc  <= 1'b0;
			quiet     <= 4'h0;
		end else begin
			last_byte <= chan_a_byte_clock;
			last_osc  <= osc_clock;
			if (chan_a_byte_clock != last_byte || osc_clock != last_osc ||
				(hsel && htrans[1])) begin
				quiet <= 4'h0;
			end else if (quiet != 4'hf) begin
				quiet <= quiet + 4'h1;
			end
		end
	end

	reset_pair_a: assert property (@(posedge hclk)
		!hresetn |-> !chan_a_clock_out_p && !chan_a_clock_out_n &&
			chan_a_clock_out_oe)
		else $error("output pair not differential zero in reset");
	ref_second_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(hresetn) && $past(chan_a_refsel_in) |->
			chan_a_ref_clock == $past(ref_clock_second))
		else $error("reference does not follow the second clock");
	pins_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(!chan_a_powerdown_n && !chan_b_powerdown_n)[*5] |->
			!chan_a_clock_out_oe)
		else $error("output pair driven with both pins down");
	tx_unaligned_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!chan_a_tx_lanes_aligned |=> !chan_a_tx_aligned_out)
		else $error("alignment out high with lanes unaligned");
	pin_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!chan_a_powerdown_n |=> chan_a_powered_down)
		else $error("channel not down while its pin is low");
	dp_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
		chan_a_datapath_reset |=> !chan_a_datapath_reset)
		else $error("data path reset wider than one cycle");
	quiet_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
		quiet >= 4'ha |-> $stable(chan_a_clock_out_p))
		else $error("output clock moved with its source still");
	bus_ready_a: assert property (@(posedge hclk) disable iff (!hresetn)
		hsel && htrans[1] |=> hreadyout && hresp == CACL_HRESP_OKAY)
		else $error("bus transfer not completed with okay");
endmodule : cacl_monitor

bind cacl_top cacl_monitor u_cacl_monitor (.*);

// ### verification/cacl_link_partner.sv
// Link partner model driving the receive lane alignment status.
`timescale 1ns/100ps
module cacl_link_partner (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Partner receive lane state and its reporting lag.
	input wire logic lanes_ok,
	input wire logic slow,
	output logic     aligned_out
);
	logic [2:0] lag;

	// The slave reports unaligned until its lanes settle after reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lag <= 3'h0;
		end else begin
			lag <= {lag[1:0], lanes_ok};
		end
	end

	// A slow partner lets its status trail by three cycles.
	assign aligned_out = slow ? lag[2] : lag[0];
endmodule : cacl_link_partner

// ### verification/cacl_top_tb_top.sv
// Self-checking testbench for the channel A clock and status block.
`timescale 1ns/100ps
module cacl_top_tb_top;
	import cacl_pkg::*;
	localparam logic [31:0] DEF = 32'(CACL_CTRL_RESET);
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic        ref_clock_first, ref_clock_second, chan_a_refsel_in;
	logic        chan_a_ref_clock, chan_a_byte_clock, osc_clock;
	logic        chan_b_native_clock, chan_a_partner_aligned_in;
	logic        chan_a_clock_out_p, chan_a_clock_out_n, chan_a_clock_out_oe;
	logic        chan_b_clock_out_p, chan_b_clock_out_n, chan_b_clock_out_oe;
	logic        chan_a_tx_lanes_aligned, chan_a_tx_aligned_out;
	logic        chan_a_powerdown_n, chan_b_powerdown_n;
	logic        chan_a_powered_down, chan_a_datapath_reset;
	logic        run_src, lanes_ok, slow;
	int          cyc, fails, n_compared, pulses;

	assign hready = hreadyout;
	cacl_top u_cacl_top (.*);
	cacl_link_partner u_cacl_link_partner (.hclk(hclk), .hresetn(hresetn),
		.lanes_ok(lanes_ok), .slow(slow),
		.aligned_out(chan_a_partner_aligned_in));

	// Free-running bus clock.
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// Slow clock sources; the byte clock has a period of 20 cycles.
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		ref_clock_first <= ~ref_clock_first;
		if (cyc % 4 == 0) ref_clock_second <= ~ref_clock_second;
		if (run_src && cyc % 10 == 0) chan_a_byte_clock <= ~chan_a_byte_clock;
		if (run_src && cyc % 3 == 0) osc_clock <= ~osc_clock;
		if (cyc % 7 == 0) chan_b_native_clock <= ~chan_b_native_clock;
		if (chan_a_datapath_reset === 1'b1) pulses <= pulses + 1;
	end

	task automatic summarize();
		$display("compared=%0d fails=%0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask : tick

	// Waits for the slave's ready under a bound; a hang ends the run.
	task automatic wait_rdy();
		for (int i = 0; i < 20; i++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) return;
		end
		fails++;
		summarize();
	endtask : wait_rdy

	task automatic ahb_xfer(input logic w, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= CACL_HTRANS_NONSEQ;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		tick(1);
	endtask : ahb_xfer

	task automatic wr_ctrl(input logic [31:0] v);
		logic [31:0] d;
		ahb_xfer(1'b1, {24'h0, CACL_OFS_CTRL}, v, d);
	endtask : wr_ctrl

	task automatic stat_chk(input int b, input logic e);
		logic [31:0] d;
		ahb_xfer(1'b0, {24'h0, CACL_OFS_STATUS}, 32'h0, d);
		chk(d[b], e);
	endtask : stat_chk

	// Measures one settled output clock period in bus cycles.
	task automatic period(input bit use_b, input int exp);
		int r, n;
		logic pv, cv;
		r = 0;
		n = 0;
		pv = 1'b1;
		for (int i = 0; i < 3000 && r < 4; i++) begin
			@(posedge hclk);
			cv = use_b ? chan_b_clock_out_p : chan_a_clock_out_p;
			if (cv === 1'b1 && pv === 1'b0) r++;
			else if (r == 3) n++;
			pv = cv;
		end
		if (r < 4) begin
			fails++;
			summarize();
		end
		chk(n + 1, exp);
		chk(chan_a_clock_out_oe, 1'b1);
		chk(use_b ? chan_b_clock_out_n : chan_a_clock_out_n, {31'h0, ~cv});
	endtask : period

	task automatic t_regs();
		logic [31:0] d;
		ahb_xfer(1'b0, {24'h0, CACL_OFS_CTRL}, 32'h0, d);
		chk(d, DEF);
		ahb_xfer(1'b0, 32'h8, 32'h0, d);
		chk(d, 32'h0);
		ahb_xfer(1'b1, {24'h0, CACL_OFS_STATUS}, 32'hff, d);
		stat_chk(CACL_STAT_REF_SECOND, 1'b0);
	endtask : t_regs

	task automatic t_refsel();
		logic e;
		for (int s = 0; s < 2; s++) begin
			chan_a_refsel_in <= s[0];
			tick(2);
			repeat (6) begin
				@(posedge hclk);
				e = s[0] ? ref_clock_second : ref_clock_first;
				#1 chk(chan_a_ref_clock, e);
			end
		end
		chan_a_refsel_in <= 1'b0;
		wr_ctrl(DEF | (32'h1 << CACL_CTRL_REFSEL));
		stat_chk(CACL_STAT_REF_SECOND, 1'b1);
		wr_ctrl(DEF);
	endtask : t_refsel

	task automatic t_clocks();
		for (int i = 0; i < CACL_NUM_RATIOS; i++) begin
			wr_ctrl(DEF | 32'(i << CACL_CTRL_DIV_LO));
			period(1'b0, 20 * CACL_RATIOS[i]);
		end
		wr_ctrl(DEF | (32'h1 << CACL_CTRL_OSCSRC));
		period(1'b0, 12);
		wr_ctrl(DEF | (32'hf << CACL_CTRL_DIV_LO));
		period(1'b0, 20);
		wr_ctrl(DEF & ~(32'h1 << CACL_CTRL_CLKEN));
		tick(4);
		chk({chan_a_clock_out_p, chan_a_clock_out_n,
			chan_a_clock_out_oe}, 3'b001);
		wr_ctrl(DEF);
		period(1'b1, 14);
		wr_ctrl(DEF | (32'h1 << CACL_CTRL_ROUTE_B));
		period(1'b1, 20);
		run_src <= 1'b0;
		tick(20);
		run_src <= 1'b1;
		wr_ctrl(DEF);
	endtask : t_clocks

	task automatic t_power();
		int p0;
		chan_a_powerdown_n <= 1'b0;
		chan_b_powerdown_n <= 1'b0;
		tick(6);
		chk({chan_a_clock_out_oe, chan_b_clock_out_oe}, 2'b00);
		stat_chk(CACL_STAT_CLK_OFF, 1'b1);
		chan_a_powerdown_n <= 1'b1;
		tick(6);
		chk(chan_a_clock_out_oe, 1'b1);
		stat_chk(CACL_STAT_NEED_DPRST, 1'b1);
		p0 = pulses;
		wr_ctrl(DEF | (32'h1 << CACL_CTRL_DP_RESET));
		tick(2);
		chk(pulses - p0, 1);
		stat_chk(CACL_STAT_NEED_DPRST, 1'b0);
		chan_b_powerdown_n <= 1'b1;
		wr_ctrl(DEF | (32'h1 << CACL_CTRL_PD_A));
		tick(6);
		chk(chan_a_clock_out_oe, 1'b1);
		wr_ctrl(DEF | (32'h3 << CACL_CTRL_PD_A));
		tick(6);
		chk(chan_a_clock_out_oe, 1'b0);
		wr_ctrl(DEF);
	endtask : t_power

	task automatic t_status();
		chan_a_tx_lanes_aligned <= 1'b1;
		tick(3);
		chk(chan_a_tx_aligned_out, 1'b1);
		chan_a_powerdown_n <= 1'b0;
		tick(3);
		chk({chan_a_powered_down, chan_a_tx_aligned_out}, 2'b10);
		stat_chk(CACL_STAT_A_DOWN, 1'b1);
		chan_a_powerdown_n <= 1'b1;
		tick(3);
		chk(chan_a_powered_down, 1'b0);
		wr_ctrl(DEF | (32'h1 << CACL_CTRL_DP_RESET));
		chan_a_tx_lanes_aligned <= 1'b0;
		tick(3);
		chk(chan_a_tx_aligned_out, 1'b0);
		for (int k = 0; k < 2; k++) begin
			slow <= k[0];
			lanes_ok <= 1'b1;
			tick(6);
			stat_chk(CACL_STAT_PARTNER_OK, 1'b1);
			lanes_ok <= 1'b0;
			tick(6);
			stat_chk(CACL_STAT_PARTNER_OK, 1'b0);
		end
	endtask : t_status

	// A second reset in mid-run must restore the pair and defaults.
	task automatic t_rereset();
		logic [31:0] d;
		wr_ctrl(DEF | (32'h1 << CACL_CTRL_REFSEL));
		hresetn <= 1'b0;
		tick(3);
		chk({chan_a_clock_out_p, chan_a_clock_out_n,
			chan_a_clock_out_oe}, 3'b001);
		hresetn <= 1'b1;
		tick(1);
		ahb_xfer(1'b0, {24'h0, CACL_OFS_CTRL}, 32'h0, d);
		chk(d, DEF);
	endtask : t_rereset

	// Main sequence.
	initial begin
		// Reset falls just after time zero so that every flop sees its edge.
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hresetn = 1'b1;
		hsize = 3'h2;
		{ref_clock_first, ref_clock_second, chan_a_refsel_in} = 3'h0;
		{chan_a_byte_clock, osc_clock, chan_b_native_clock} = 3'h0;
		{chan_a_tx_lanes_aligned, lanes_ok, slow} = 3'h0;
		{chan_a_powerdown_n, chan_b_powerdown_n, run_src} = 3'h7;
		{cyc, fails, n_compared, pulses} = '0;
		#1 hresetn = 1'b0;
		tick(10);
		chk({chan_a_clock_out_p, chan_a_clock_out_n,
			chan_a_clock_out_oe}, 3'b001);
		hresetn <= 1'b1;
		tick(1);
		t_regs();
		t_refsel();
		t_clocks();
		t_power();
		t_status();
		t_rereset();
		summarize();
	end
endmodule : cacl_top_tb_top
